// ---- verilog/seq_pkg.sv ----
// constants for the crystal switch and crucible sequencer
package seq_pkg;
	// ===================================================
	// register offsets and reset values
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_TIMING = 8'h04;
	localparam logic [7:0] OFS_COMMAND = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] TIMING_RESET = 32'h0005_0101;
	localparam logic [6:0] CRUCIBLE_RESET = 7'h01;
	// ===================================================
	// field positions
	localparam int CFG_SENSOR_LSB = 0;
	localparam int CFG_POSN_LSB = 3;
	localparam int CFG_FIRST_LSB = 7;
	localparam int CFG_LAST_LSB = 11;
	localparam int CFG_ACTION_LSB = 15;
	localparam int CFG_FEEDBACK_BIT = 17;
	localparam int CFG_RELAY_LSB = 18;
	localparam int CFG_PULSES_LSB = 22;
	localparam int TIM_ON_LSB = 0;
	localparam int TIM_OFF_LSB = 8;
	localparam int TIM_TURRET_LSB = 16;
	localparam int CMD_START = 0;
	localparam int CMD_MANUAL = 1;
	localparam int CMD_ROTATE = 2;
	localparam int CMD_REINSERT = 3;
	localparam int CMD_CRUC_LSB = 8;
	localparam int ST_POS_LSB = 0;
	localparam int ST_FAIL_LSB = 4;
	localparam int ST_BUSY_BIT = 16;
	localparam int ST_XFAIL_BIT = 17;
	localparam int ST_SWERR_BIT = 18;
	localparam int ST_MOVE_BIT = 19;
	localparam int ST_CRUC_LSB = 20;
	// ===================================================
	// encodings
	localparam logic [2:0] SENS_SINGLE = 3'h0;
	localparam logic [2:0] SENS_DUAL = 3'h1;
	localparam logic [2:0] SENS_SIX = 3'h2;
	localparam logic [2:0] SENS_TWELVE = 3'h3;
	localparam logic [2:0] SENS_GENERIC = 3'h4;
	localparam logic [1:0] ACT_HOLD = 2'h0;
	localparam logic [1:0] ACT_POSTDEP = 2'h1;
	localparam logic [1:0] ACT_STOPMAT = 2'h2;
	localparam logic [1:0] ACT_STOPALL = 2'h3;
	localparam logic [2:0] PH_IDLE = 3'h0;
	localparam logic [2:0] PH_READY = 3'h1;
	localparam logic [2:0] PH_STOP = 3'h2;
	localparam logic [2:0] PH_PREDEP = 3'h3;
	localparam logic [2:0] PH_DEPOSIT = 3'h4;
	localparam logic [2:0] PH_RUN = 3'h5;
	// ===================================================
	// timing and counts
	localparam longint ONE_SECOND_NS = 1000000000;
	localparam longint CLK_PERIOD_NS = 5;
	localparam logic [3:0] STEP_ERROR_LIMIT = 4'hD;
	localparam logic [3:0] CATALOG_STEPS = 4'hC;
	localparam logic [3:0] RELOAD_POSITION = 4'hC;
	localparam logic [3:0] SIX_PULSES = 4'h2;
endpackage

// ---- verilog/crystal_switch_crucible_sequencer.sv ----
// sensor head crystal switching and crucible turret sequencing
// Behaviour
// - dual head: active crystal fails while running, other good -> switch
// - six, twelve or generic: fail while running with a good crystal -> switch
// - start with six/twelve outside first..last position range -> switch
// - signal quality limits exceeded in deposit -> switch
// - no automatic switch in stop, ready or idle
// - failure in pre-deposit never switches; hold action stops the material
// - last good crystal fails: no switch, crystal fail state, failure action
// - manual switch from five sources, only with a multi-position head
// - dual head selected by a config write: secondary crystal checked good
// - six head step: close 1 s, open 1 s, close 1 s, open
// - twelve head init: find position 1, step 12 more, end at 1
// - twelve step sense mismatch repulses; 13 wrong pulses -> switch error
// - carousel reinserted: position 12, all failed, until catalogued
// - rotate head only in ready, stop or idle
// - twelve head step: single 1 s closure then open
// - generic move: configured pulses of on then off time, untracked
// - generic: resonance search, at most positions minus one attempts
// - start resets every crystal failure flag
// - up to 64 crucibles on six coded relays, move on start if different
// - resume after turret delay or in-position input per feedback option
// - nonzero source power dropped to zero before crucible change
// - relay code is crucible minus one, LSB on the first relay
//
// Chosen here: the plain strobed port and the register addresses.
module crystal_switch_crucible_sequencer
	import seq_pkg::*;
#(
	parameter int SECOND_CYCLES = int'(ONE_SECOND_NS / CLK_PERIOD_NS)
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	input wire logic [2:0] material_phase,
	input wire logic crystal_failed,
	input wire logic sq_exceeded,
	input wire logic crystal_good,
	input wire logic resonance_found,
	input wire logic resonance_fail,
	input wire logic panel_switch,
	input wire logic handheld_switch,
	input wire logic remote_switch_sensor_command,
	input wire logic logic_switch,
	input wire logic source_power_nonzero,
	input wire logic position_sense_ok,
	input wire logic position_one_sensed,
	input wire logic turret_in_position,
	output logic switch_relay,
	output logic [15:0] crucible_relays,
	output logic [3:0] sense_expect,
	output logic crystal_fail_state,
	output logic switch_sequence_error,
	output logic hold_power_req,
	output logic post_deposit_state_req,
	output logic stop_material_req,
	output logic stop_all_req,
	output logic power_zero_req,
	output logic crucible_move_state,
	output logic resume_sequence,
	output logic switch_busy
);
	// ===================================================
	// types and helpers
	typedef enum logic [2:0] {SW_IDLE, SW_ON, SW_OFF, SW_CHECK, SW_RESON}
		sw_state_t;
	typedef enum logic [1:0] {OP_STEP, OP_FIND, OP_CATALOG, OP_DUAL_CHECK}
		op_t;
	typedef enum logic [1:0] {CR_IDLE, CR_POWER, CR_MOVE} cr_state_t;

	function automatic logic [3:0] next_pos(input logic [3:0] p,
		input logic [3:0] mx);
		return (p >= mx) ? 4'h1 : 4'(p + 4'h1);
	endfunction

	function automatic logic [11:0] pos_bit(input logic [3:0] p);
		return (p == 4'h0) ? 12'h000 : 12'(12'h001 << (p - 4'h1));
	endfunction

	function automatic logic [7:0] at_least_one(input logic [7:0] t);
		return (t == 8'h00) ? 8'h01 : t;
	endfunction

	// ===================================================
	// pin synchronisers: three stages, change taken when 2 and 3 agree
	logic [2:0] pin_s1, pin_s2, pin_s3, pin_f;
	wire [2:0] pins = {turret_in_position, position_one_sensed,
		position_sense_ok};
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			pin_s3 <= 3'h0;
			pin_f <= 3'h0;
		end else begin
			pin_s1 <= pins;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
		end
	end
	wire sense_ok = pin_f[0];
	wire one_sensed = pin_f[1];
	wire in_pos = pin_f[2];

	// ===================================================
	// registers and decode
	logic [31:0] cfg, tim;
	sw_state_t sw_state;
	op_t op;
	cr_state_t cr_state;
	logic [3:0] pos, pulses_left, wrong_cnt, cat_cnt, attempts;
	logic [11:0] failed;
	logic [7:0] ticks_left, cr_ticks;
	logic [31:0] cyc_cnt, free_cnt;
	logic dual_second, pend_switch, pend_rotate, pend_init, uncataloged;
	logic [3:0] action;
	logic [6:0] cruc_cur, cruc_req;

	wire [2:0] sensor = cfg[CFG_SENSOR_LSB +: 3];
	wire [3:0] posn = cfg[CFG_POSN_LSB +: 4];
	wire [3:0] first_pos = cfg[CFG_FIRST_LSB +: 4];
	wire [3:0] last_pos = cfg[CFG_LAST_LSB +: 4];
	wire [1:0] fail_act = cfg[CFG_ACTION_LSB +: 2];
	wire feedback_en = cfg[CFG_FEEDBACK_BIT];
	wire [3:0] relay_first = cfg[CFG_RELAY_LSB +: 4];
	wire is_dual = sensor == SENS_DUAL;
	wire is_six = sensor == SENS_SIX;
	wire is_twelve = sensor == SENS_TWELVE;
	wire is_generic = sensor == SENS_GENERIC;
	wire multi = is_dual | is_six | is_twelve | is_generic;
	wire [3:0] pos_max = is_six ? 4'h6 : 4'hC;
	wire [11:0] pos_mask = is_dual ? 12'h003 : is_six ? 12'h03F :
		(is_twelve | is_generic) ? 12'hFFF : 12'h001;
	wire [11:0] cur_bit = pos_bit(pos);
	wire [3:0] pos_ahead = next_pos(pos, pos_max);
	wire has_good = |(~failed & pos_mask & ~cur_bit);
	wire can_move = is_generic | has_good;

	wire wr_cmd = bus_wr && (bus_addr == OFS_COMMAND);
	wire wr_cfg = bus_wr && (bus_addr == OFS_CONFIG);
	wire wr_tim = bus_wr && (bus_addr == OFS_TIMING);
	wire cmd_start = wr_cmd && bus_wdata[CMD_START];
	wire cmd_manual = wr_cmd && bus_wdata[CMD_MANUAL];
	wire cmd_rotate = wr_cmd && bus_wdata[CMD_ROTATE];
	wire cmd_reinsert = wr_cmd && bus_wdata[CMD_REINSERT];
	wire [6:0] cmd_cruc = bus_wdata[CMD_CRUC_LSB +: 7];
	wire [2:0] new_sensor = bus_wdata[CFG_SENSOR_LSB +: 3];

	wire quiet = (material_phase == PH_IDLE) ||
		(material_phase == PH_READY) || (material_phase == PH_STOP);
	wire active = (material_phase == PH_DEPOSIT) ||
		(material_phase == PH_RUN);
	// switch triggers; quiet phases reach only the start, manual and rotate ones
	wire auto_sw = crystal_failed && active && multi && can_move;
	wire exhaust = crystal_failed && active && !is_generic && !has_good;
	wire predep_hold = crystal_failed && (material_phase == PH_PREDEP) &&
		(fail_act == ACT_HOLD);
	wire sq_sw = sq_exceeded && (material_phase == PH_DEPOSIT) && multi &&
		can_move;
	wire start_sw = cmd_start && (is_six || is_twelve) &&
		((pos < first_pos) || (pos > last_pos));
	wire manual_sw = multi && (cmd_manual || panel_switch ||
		handheld_switch || remote_switch_sensor_command || logic_switch);
	wire rot_trig = cmd_rotate && quiet && is_twelve;
	wire sw_trig = auto_sw || sq_sw || start_sw || manual_sw;

	// step shape per head type
	wire [3:0] pulses_for = is_six ? SIX_PULSES : is_generic ?
		((cfg[CFG_PULSES_LSB +: 4] == 4'h0) ? 4'h1 : cfg[CFG_PULSES_LSB +: 4])
		: 4'h1;
	wire [7:0] on_for = is_generic ? at_least_one(tim[TIM_ON_LSB +: 8]) :
		8'h01;
	wire [7:0] off_for = is_generic ? at_least_one(tim[TIM_OFF_LSB +: 8]) :
		8'h01;

	wire sec_wrap = cyc_cnt == 32'(SECOND_CYCLES - 1);
	wire phase_end = sec_wrap && (ticks_left == 8'h01);
	wire idle = sw_state == SW_IDLE;
	wire launch_init = idle && pend_init;
	wire launch_find = idle && !pend_init &&
		(pend_rotate || (pend_switch && is_twelve && uncataloged));
	wire launch_step = idle && !pend_init && !launch_find && pend_switch;

	// ===================================================
	// deferred requests: a new one is held while a sequence runs
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pend_switch <= 1'b0;
			pend_rotate <= 1'b0;
			pend_init <= 1'b0;
		end else begin
			pend_switch <= (pend_switch && !launch_step && !launch_find) ||
				sw_trig;
			pend_rotate <= (pend_rotate && !launch_find) || rot_trig;
			pend_init <= (pend_init && !launch_init) || (wr_cfg &&
				(new_sensor == SENS_DUAL || new_sensor == SENS_TWELVE));
		end
	end

	// ===================================================
	// switch sequencer
	task automatic launch(input op_t o);
		sw_state <= SW_ON;
		op <= o;
		pulses_left <= pulses_for;
		ticks_left <= on_for;
		cyc_cnt <= 32'h0;
		sense_expect <= pos_ahead;
	endtask

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sw_state <= SW_IDLE;
			op <= OP_STEP;
			pos <= 4'h1;
			failed <= 12'h000;
			pulses_left <= 4'h0;
			ticks_left <= 8'h00;
			cyc_cnt <= 32'h0;
			wrong_cnt <= 4'h0;
			cat_cnt <= 4'h0;
			attempts <= 4'h0;
			dual_second <= 1'b0;
			uncataloged <= 1'b0;
			crystal_fail_state <= 1'b0;
			switch_sequence_error <= 1'b0;
			action <= 4'h0;
			sense_expect <= 4'h1;
		end else begin
			action <= 4'h0;
			if (cmd_start) begin
				failed <= 12'h000;
				crystal_fail_state <= 1'b0;
				switch_sequence_error <= 1'b0;
			end
			if (cmd_reinsert && is_twelve) begin
				pos <= RELOAD_POSITION;
				failed <= 12'hFFF;
				uncataloged <= 1'b1;
			end
			if (predep_hold)
				action <= 4'(4'h1 << ACT_STOPMAT);
			if (exhaust) begin
				crystal_fail_state <= 1'b1;
				action <= 4'(4'h1 << fail_act);
			end
			case (sw_state)
				SW_IDLE: begin
					wrong_cnt <= 4'h0;
					attempts <= 4'h0;
					if (launch_init) begin
						if (is_dual)
							launch(OP_DUAL_CHECK);
						else
							launch(OP_FIND);
					end else if (launch_find) begin
						launch(OP_FIND);
					end else if (launch_step) begin
						if (is_dual) begin
							dual_second <= !dual_second;
							pos <= dual_second ? 4'h1 : 4'h2;
						end else begin
							launch(OP_STEP);
						end
					end
				end
				SW_ON, SW_OFF: begin
					cyc_cnt <= sec_wrap ? 32'h0 : cyc_cnt + 32'h1;
					if (sec_wrap)
						ticks_left <= ticks_left - 8'h01;
					if (phase_end) begin
						if (sw_state == SW_ON && op == OP_DUAL_CHECK) begin
							if (!crystal_good)
								failed <= failed | 12'h002;
							sw_state <= SW_IDLE;
						end else if (sw_state == SW_ON) begin
							sw_state <= SW_OFF;
							ticks_left <= off_for;
						end else if (pulses_left > 4'h1) begin
							pulses_left <= pulses_left - 4'h1;
							sw_state <= SW_ON;
							ticks_left <= on_for;
						end else begin
							sw_state <= SW_CHECK;
						end
					end
				end
				SW_CHECK: begin
					if (is_generic) begin
						sw_state <= SW_RESON;
					end else if (op == OP_FIND) begin
						if (one_sensed) begin
							pos <= 4'h1;
							op <= OP_CATALOG;
							cat_cnt <= 4'h1;
							failed <= 12'hFFE | {11'h0, !crystal_good};
							launch(OP_CATALOG);
							sense_expect <= next_pos(4'h1, pos_max);
						end else if (wrong_cnt + 4'h1 >= STEP_ERROR_LIMIT) begin
							switch_sequence_error <= 1'b1;
							failed <= 12'hFFF & ~cur_bit;
							uncataloged <= 1'b0;
							sw_state <= SW_IDLE;
						end else begin
							wrong_cnt <= wrong_cnt + 4'h1;
							launch(OP_FIND);
						end
					end else if (is_twelve && !sense_ok) begin
						if (wrong_cnt + 4'h1 >= STEP_ERROR_LIMIT) begin
							switch_sequence_error <= 1'b1;
							failed <= 12'hFFF & ~cur_bit;
							uncataloged <= 1'b0;
							sw_state <= SW_IDLE;
						end else begin
							wrong_cnt <= wrong_cnt + 4'h1;
							launch(op);
						end
					end else if (op == OP_CATALOG) begin
						pos <= pos_ahead;
						if (cat_cnt == CATALOG_STEPS) begin
							uncataloged <= 1'b0;
							sw_state <= SW_IDLE;
						end else begin
							cat_cnt <= cat_cnt + 4'h1;
							if (crystal_good)
								failed <= failed & ~pos_bit(pos_ahead);
							launch(OP_CATALOG);
							// pos moves this cycle, so expect the one after it
							sense_expect <= next_pos(pos_ahead, pos_max);
						end
					end else begin
						pos <= pos_ahead;
						if ((failed & pos_bit(pos_ahead)) != 12'h000 && has_good) begin
							launch(OP_STEP);
							sense_expect <= next_pos(pos_ahead, pos_max);
						end else begin
							sw_state <= SW_IDLE;
						end
					end
				end
				SW_RESON: begin
					if (resonance_found) begin
						sw_state <= SW_IDLE;
					end else if (resonance_fail) begin
						if (attempts + 4'h1 >= posn - 4'h1) begin
							crystal_fail_state <= 1'b1;
							action <= 4'(4'h1 << fail_act);
							sw_state <= SW_IDLE;
						end else begin
							attempts <= attempts + 4'h1;
							launch(OP_STEP);
						end
					end
				end
				default: sw_state <= SW_IDLE;
			endcase
			if (crystal_failed && !is_generic)
				failed <= ((cmd_reinsert && is_twelve) ? 12'hFFF :
					cmd_start ? 12'h000 : failed) | cur_bit; // set wins over clear
		end
	end

	// stale dual level must not hold the relay after a head type change
	assign switch_relay = (sw_state == SW_ON) || (dual_second && is_dual);
	assign switch_busy = !idle;
	assign hold_power_req = action[ACT_HOLD];
	assign post_deposit_state_req = action[ACT_POSTDEP];
	assign stop_material_req = action[ACT_STOPMAT];
	assign stop_all_req = action[ACT_STOPALL];

	// ===================================================
	// crucible turret
	// delay counts whole free-running seconds; one extra so it is never short
	wire free_tick = free_cnt == 32'(SECOND_CYCLES - 1);
	wire [7:0] turret_delay = tim[TIM_TURRET_LSB +: 8];
	wire [15:0] relay_word = 16'({10'h000, 6'(cruc_req - 7'h01)} <<
		relay_first);
	wire turret_done = feedback_en ? in_pos : (cr_ticks > turret_delay);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cr_state <= CR_IDLE;
			cruc_cur <= CRUCIBLE_RESET;
			cruc_req <= CRUCIBLE_RESET;
			cr_ticks <= 8'h00;
			free_cnt <= 32'h0;
			crucible_relays <= 16'h0000;
			resume_sequence <= 1'b0;
		end else begin
			free_cnt <= free_tick ? 32'h0 : free_cnt + 32'h1;
			resume_sequence <= 1'b0;
			case (cr_state)
				CR_IDLE: begin
					if (cmd_start) begin
						cruc_req <= cmd_cruc;
						if (cmd_cruc != cruc_cur && cmd_cruc != 7'h00)
							cr_state <= CR_POWER;
						else
							resume_sequence <= 1'b1;
					end
				end
				CR_POWER: begin
					if (!source_power_nonzero) begin
						cr_state <= CR_MOVE;
						crucible_relays <= relay_word;
						cr_ticks <= 8'h00;
					end
				end
				CR_MOVE: begin
					if (free_tick && cr_ticks != 8'hFF)
						cr_ticks <= cr_ticks + 8'h01;
					if (turret_done) begin
						cruc_cur <= cruc_req;
						resume_sequence <= 1'b1;
						cr_state <= CR_IDLE;
					end
				end
				default: cr_state <= CR_IDLE;
			endcase
		end
	end

	assign power_zero_req = cr_state == CR_POWER;
	assign crucible_move_state = cr_state == CR_MOVE;

	// ===================================================
	// register port
	wire [31:0] status_word = {5'h00, cruc_cur, crucible_move_state,
		switch_sequence_error, crystal_fail_state, switch_busy, failed, pos};

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg <= CONFIG_RESET;
			tim <= TIMING_RESET;
			bus_rdata <= 32'h0;
		end else begin
			if (wr_cfg)
				cfg <= bus_wdata;
			if (wr_tim)
				tim <= bus_wdata;
			bus_rdata <= 32'h0;
			if (bus_rd) begin
				case (bus_addr)
					OFS_CONFIG: bus_rdata <= cfg;
					OFS_TIMING: bus_rdata <= tim;
					OFS_STATUS: bus_rdata <= status_word;
					default: bus_rdata <= 32'h0;
				endcase
			end
		end
	end

	// ===================================================
	// checks
	logic [31:0] hi_len;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			hi_len <= 32'h0;
		else
			hi_len <= (sw_state == SW_ON) ? hi_len + 32'h1 : 32'h0;
	end

	AST_QUIET_NO_SWITCH: assert property (@(posedge clk_sys)
		disable iff (!resetn) (idle && quiet && crystal_failed && !pend_switch
		&& !pend_rotate && !pend_init && !manual_sw && !start_sw)
		|=> (sw_state == SW_IDLE) && !switch_busy)
		else $error("switch started in a quiet phase");
	AST_FIXED_PULSE_WIDTH: assert property (@(posedge clk_sys)
		disable iff (!resetn) ($fell(sw_state == SW_ON) && !is_generic)
		|-> $past(hi_len) == 32'(SECOND_CYCLES - 1))
		else $error("fixed relay closure not one second");
	AST_START_CLEARS: assert property (@(posedge clk_sys)
		disable iff (!resetn) (cmd_start && !crystal_failed && !cmd_reinsert
		&& sw_state != SW_CHECK && sw_state != SW_ON) |=> failed == 12'h000)
		else $error("start left a failure flag set");
	AST_ERROR_MAP: assert property (@(posedge clk_sys)
		disable iff (!resetn) $rose(switch_sequence_error)
		|-> (failed | cur_bit) == 12'hFFF && ($past(wrong_cnt) == 4'hC ||
		$past(op) == OP_FIND))
		else $error("switch error map wrong");
	AST_POWER_BEFORE_MOVE: assert property (@(posedge clk_sys)
		disable iff (!resetn) $rose(crucible_move_state)
		|-> $past(!source_power_nonzero) && $past(power_zero_req))
		else $error("crucible moved with power on");
	AST_RELAY_CODE: assert property (@(posedge clk_sys)
		disable iff (!resetn) crucible_move_state
		|-> crucible_relays == 16'({10'h000, 6'(cruc_req - 7'h01)}
		<< relay_first))
		else $error("crucible relay code wrong");
	AST_RESUME_ON_FEEDBACK: assert property (@(posedge clk_sys)
		disable iff (!resetn) $fell(crucible_move_state)
		|-> resume_sequence && ($past(feedback_en) ? $past(in_pos) :
		$past(cr_ticks) > $past(turret_delay)))
		else $error("turret resume without its condition");
	AST_EXHAUST_ACTION: assert property (@(posedge clk_sys)
		disable iff (!resetn) (exhaust && !cmd_start && idle && !pend_switch)
		|=> crystal_fail_state && $onehot(action) && idle)
		else $error("last crystal failure mishandled");
	AST_PREDEP_STOP: assert property (@(posedge clk_sys)
		disable iff (!resetn) (predep_hold && idle && !pend_switch
		&& !pend_init && !pend_rotate && !manual_sw && !start_sw)
		|=> stop_material_req && !switch_busy)
		else $error("pre-deposit failure not stopped");
endmodule // crystal_switch_crucible_sequencer

// ---- dv/head_turret_model.sv ----
// behavioural sensor head carousel and turret position controller
module head_turret_model #(
	parameter int TURRET_CYCLES = 30
) (
	input wire logic clk_sys,
	input wire logic switch_relay,
	input wire logic [3:0] sense_expect,
	input wire logic crucible_move_state,
	output logic position_sense_ok,
	output logic position_one_sensed,
	output logic turret_in_position
);
	timeunit 1ns;
	timeprecision 1ns;
	// ===================================================
	// carousel: one position per relay closure, wraps after 12
	logic [3:0] pos = 4'h1;
	logic last = 1'b0;
	int cnt = 0;
	always @(posedge clk_sys) begin
		last <= switch_relay;
		if (switch_relay && !last)
			pos <= (pos == 4'hC) ? 4'h1 : pos + 4'h1;
		if (!crucible_move_state)
			cnt <= 0;
		else if (cnt < TURRET_CYCLES)
			cnt <= cnt + 1;
	end
	assign position_one_sensed = (pos == 4'h1);
	assign position_sense_ok = (pos == sense_expect);
	// ===================================================
	// feedback low while travelling, so an early resume shows up
	assign turret_in_position = crucible_move_state && (cnt == TURRET_CYCLES);
endmodule // head_turret_model

// ---- dv/testbench.sv ----
// self-checking bench for the crystal switch and crucible sequencer
module testbench;
	import seq_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int S = 20;
	logic clk_sys = 0, resetn = 0, bus_wr = 0, bus_rd = 0, good = 1;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0, bus_rdata, v;
	logic [2:0] material_phase = PH_READY;
	logic crystal_failed = 0, sq_exceeded = 0, source_power_nonzero = 0;
	logic [3:0] sw = 4'h0, sense_expect;
	logic switch_relay, crystal_fail_state, switch_sequence_error;
	logic hold_power_req, post_deposit_state_req, stop_material_req;
	logic stop_all_req, power_zero_req, crucible_move_state;
	logic resume_sequence, switch_busy, pso, pos1, tip;
	logic [15:0] crucible_relays;
	int fail_count = 0, cmp_count = 0, n;
	crystal_switch_crucible_sequencer #(.SECOND_CYCLES(S)) dut (.clk_sys,
		.resetn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
		.material_phase, .crystal_failed, .sq_exceeded,
		.crystal_good(good), .resonance_found(1'b0), .resonance_fail(1'b0),
		.panel_switch(sw[0]), .handheld_switch(sw[1]),
		.remote_switch_sensor_command(sw[2]), .logic_switch(sw[3]),
		.source_power_nonzero, .position_sense_ok(pso),
		.position_one_sensed(pos1), .turret_in_position(tip), .switch_relay,
		.crucible_relays, .sense_expect, .crystal_fail_state,
		.switch_sequence_error, .hold_power_req, .post_deposit_state_req,
		.stop_material_req, .stop_all_req, .power_zero_req,
		.crucible_move_state, .resume_sequence, .switch_busy);
	head_turret_model model (.clk_sys, .switch_relay, .sense_expect,
		.crucible_move_state, .position_sense_ok(pso),
		.position_one_sensed(pos1), .turret_in_position(tip));
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ===================================================
	// shared helpers
	task stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus_wr <= 1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk_sys);
		bus_wr <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		bus_rd <= 1;
		bus_addr <= a;
		@(posedge clk_sys);
		bus_rd <= 0;
		#1 v = bus_rdata;
	endtask
	// waits for a level with a bound; a hang ends the run
	task automatic wait_for(ref logic s, input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim && s !== lvl; i++)
			@(posedge clk_sys) #1;
		if (s !== lvl) begin
			chk("wait bound", 0, 1);
			stop_test();
		end
	endtask
	task run_len(input logic lvl);
		n = 0;
		while (switch_relay === lvl && n < 1000) begin
			@(posedge clk_sys) #1;
			n++;
		end
	endtask
	task fail_pulse();
		@(posedge clk_sys);
		crystal_failed <= 1;
		@(posedge clk_sys);
		crystal_failed <= 0;
	endtask
	task pulse_sw(input int k);
		@(posedge clk_sys);
		sw[k] <= 1;
		@(posedge clk_sys);
		sw[k] <= 0;
	endtask
	// ===================================================
	// scenarios
	task t_regs();
		rd(OFS_TIMING);
		chk("timing reset", v, TIMING_RESET);
		rd(OFS_CONFIG);
		chk("config reset", v, CONFIG_RESET);
		rd(8'h40);
		chk("unmapped read", v, 32'h0);
	endtask
	task t_single_manual();
		pulse_sw(0);
		repeat (6) @(posedge clk_sys);
		chk("single busy", switch_busy, 1'b0);
	endtask
	task t_six_steps();
		wr(OFS_CONFIG, 32'h0000_0002);
		for (int k = 0; k < 4; k++) begin
			pulse_sw(k);
			wait_for(switch_relay, 1'b1, 10);
			chk("six busy", switch_busy, 1'b1);
			run_len(1'b1);
			chk("six on 1", n, S);
			run_len(1'b0);
			chk("six off", n, S);
			run_len(1'b1);
			chk("six on 2", n, S);
			wait_for(switch_busy, 1'b0, 4 * S);
		end
	endtask
	task t_quiet_fail();
		material_phase <= PH_IDLE;
		@(posedge clk_sys);
		crystal_failed <= 1;
		sq_exceeded <= 1;
		@(posedge clk_sys);
		crystal_failed <= 0;
		sq_exceeded <= 0;
		repeat (6) @(posedge clk_sys);
		chk("idle auto switch", switch_busy, 1'b0);
		material_phase <= PH_DEPOSIT;
	endtask
	task t_crucible();
		wr(OFS_CONFIG, 32'h0002_0002 | (32'h2 << CFG_RELAY_LSB));
		source_power_nonzero <= 1;
		wr(OFS_COMMAND, 32'h0000_0301);
		wait_for(power_zero_req, 1'b1, 10);
		repeat (4) @(posedge clk_sys);
		chk("move before zero", crucible_move_state, 1'b0);
		source_power_nonzero <= 0;
		wait_for(crucible_move_state, 1'b1, 10);
		chk("relay code", crucible_relays, 16'h0008);
		wait_for(resume_sequence, 1'b1, 60);
		chk("feedback wait", crucible_move_state, 1'b0);
		rd(OFS_STATUS);
		chk("crucible", v[26:20], 7'h03);
	endtask
	// mid-run reset, then a full find and catalog pass
	task t_twelve();
		@(posedge clk_sys);
		resetn <= 0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1;
		wr(OFS_CONFIG, 32'h0000_0003);
		wait_for(switch_busy, 1'b1, 4);
		wait_for(switch_busy, 1'b0, 30 * (2 * S + 2));
		rd(OFS_STATUS);
		chk("twelve pos", v[3:0], 4'h1);
		chk("twelve map", v[18:4], 15'h0000);
	endtask
	task t_dual();
		@(posedge clk_sys);
		good <= 0;
		wr(OFS_CONFIG, 32'h0001_8001);
		wait_for(switch_busy, 1'b1, 4);
		wait_for(switch_busy, 1'b0, 2 * S);
		rd(OFS_STATUS);
		chk("dual check", v[15:4], 12'h002);
		wr(OFS_COMMAND, 32'h0000_0001);
		rd(OFS_STATUS);
		chk("start clear", v[15:4], 12'h000);
		fail_pulse();
		repeat (3) @(posedge clk_sys);
		chk("dual relay", switch_relay, 1'b1);
		fail_pulse();
		#1 chk("stop all", stop_all_req, 1'b1);
		chk("xtal fail", crystal_fail_state, 1'b1);
		@(posedge clk_sys);
		material_phase <= PH_PREDEP;
		wr(OFS_CONFIG, 32'h0000_0001);
		fail_pulse();
		#1 chk("predep stop", stop_material_req, 1'b1);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		resetn <= 1;
		t_regs();
		t_single_manual();
		t_six_steps();
		t_quiet_fail();
		t_crucible();
		t_twelve();
		t_dual();
		stop_test();
	end
endmodule // testbench
